// ---- core/steering_input_map_scaling.v ----
// Functional notes
// - All inputs reset unmapped; unmapped inputs ignore CAN messages and pin samples.
// - Steering wheel angle mapping: 0 absent, 255 present on CAN.
// - Second and third priority devices: 0 absent, 1 channel one, 2 two, 4 CAN.
// - Primary wheel position mapping uses the same 0/1/2/4 encoding.
// - External set-point controller and vehicle speed: 0 absent, 255 on CAN.
// - Redundant wheel sensor: 0 absent, 255 present on primary's interface type.
// - Backup unit mapping only enables conflict monitoring, never a steering source.
// - Deactivate command silences the second or third priority device or the set-point controller.
// - Each analogue channel yields an unsigned code 0 to 1023.
// - Running average of 5 samples taken within each 5 ms.
// - Redundant sensor on both channels: compare the two scaled values.
// - Mapped channel sample outside 20..967 flags a short.
// - Out-of-range signal trips the signal validation monitor output.
// - Curve select per channel: 255 three-point linear, 0 five-point.
// - Three points default 100/500/900, each limited to 30..957.
// - Five-point adds half points, default 300 and 700.
// - Non-monotonic calibration sets are refused.
// - With compensation on, range check uses supply-compensated sample.
// - Position input on either channel; ends are end-locks, middle straight ahead.
`timescale 1ns/10ps
`include "steering_input_regs.vh"
module steering_input_map_scaling #(
    parameter [16:0] SAMPLE_CYCLES = (`WINDOW_MS * `CLK_KHZ) / 5
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [9:0] adc_ch1_i,
    input wire [9:0] adc_ch2_i,
    input wire [9:0] vext_i,
    input wire can_valid_i,
    input wire [2:0] can_kind_i,
    input wire [7:0] can_src_i,
    output reg can_accept_o,
    output reg backup_monitor_o,
    output reg signal_fault_o,
    output reg mismatch_o,
    output reg [11:0] scaled_ch1_o,
    output reg [11:0] scaled_ch2_o
);

////////////////////////////////////////////////////////////////////////////////
reg [7:0] map_wheel_r, map_high_r, map_low_r, map_pos_r;
reg [7:0] map_setpt_r, map_redund_r, map_speed_r, map_backup_r;
reg [7:0] speed_id_r;
reg [2:0] deact_r;
reg [1:0] comp_en_r;
reg [7:0] curve_r [0:1];
reg [7:0] sh_curve_r [0:1];
reg [9:0] cal_r [0:9];
reg [9:0] sh_r [0:9];
reg [1:0] refused_r;
reg [9:0] tol_r;
reg [16:0] div_r;
reg tick_r;
wire [1:0] cal_ok;
wire [1:0] ch_used;
wire [1:0] range_bad;
wire [9:0] avg_w [0:1];
wire signed [11:0] scl_w [0:1];
wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
wire rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire [2:0] cal_k = wb_adr_i[4:2];
wire cal_hit = (wb_adr_i[7:6] == 2'b01) & (cal_k < 3'd5);
wire [3:0] cal_i = {3'b000, wb_adr_i[5]} * 4'd5 + {1'b0, cal_k};
wire pos_ana = (map_pos_r == `MAP_CH1) | (map_pos_r == `MAP_CH2);
wire redund_on = (map_redund_r == `MAP_PRESENT);

// Legal mapping codes; anything else leaves the register unchanged.
function legal4;
    input [7:0] v;
    begin
        legal4 = (v == `MAP_NONE) | (v == `MAP_CH1) | (v == `MAP_CH2) | (v == `MAP_CAN);
    end
endfunction
function legal255;
    input [7:0] v;
    begin
        legal255 = (v == `MAP_NONE) | (v == `MAP_PRESENT);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Sample tick: five samples land inside every window.
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        div_r <= 17'h00000;
        tick_r <= 1'b0;
    end
    else if (div_r == SAMPLE_CYCLES - 17'h00001)
    begin
        div_r <= 17'h00000;
        tick_r <= 1'b1;
    end
    else
    begin
        div_r <= div_r + 17'h00001;
        tick_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes. Calibration lands in a shadow set and only moves
// to the live set on a commit that passes the checks, so the scaling
// never sees a half-written curve.
integer i;
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        map_wheel_r <= `MAP_NONE;
        map_high_r <= `MAP_NONE;
        map_low_r <= `MAP_NONE;
        map_pos_r <= `MAP_NONE;
        map_setpt_r <= `MAP_NONE;
        map_redund_r <= `MAP_NONE;
        map_speed_r <= `MAP_NONE;
        map_backup_r <= `MAP_NONE;
        speed_id_r <= 8'h00;
        deact_r <= 3'h0;
        comp_en_r <= 2'h0;
        refused_r <= 2'h0;
        tol_r <= `TOL_RST;
        for (i = 0; i < 2; i = i + 1)
        begin
            curve_r[i] <= `CURVE_LINEAR;
            sh_curve_r[i] <= `CURVE_LINEAR;
            cal_r[i*5] <= `CAL_RST_L;
            cal_r[i*5+1] <= `CAL_RST_HL;
            cal_r[i*5+2] <= `CAL_RST_N;
            cal_r[i*5+3] <= `CAL_RST_HR;
            cal_r[i*5+4] <= `CAL_RST_R;
            sh_r[i*5] <= `CAL_RST_L;
            sh_r[i*5+1] <= `CAL_RST_HL;
            sh_r[i*5+2] <= `CAL_RST_N;
            sh_r[i*5+3] <= `CAL_RST_HR;
            sh_r[i*5+4] <= `CAL_RST_R;
        end
    end
    else if (wr)
    begin
        if (wb_adr_i == `A_MAP_WHEEL)
        begin
            if (legal255(wb_dat_i[7:0]))
                map_wheel_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_HIGH)
        begin
            if (legal4(wb_dat_i[7:0]))
                map_high_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_LOW)
        begin
            if (legal4(wb_dat_i[7:0]))
                map_low_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_POS)
        begin
            if (legal4(wb_dat_i[7:0]))
                map_pos_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_SETPT)
        begin
            if (legal255(wb_dat_i[7:0]))
                map_setpt_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_REDUND)
        begin
            if (legal255(wb_dat_i[7:0]))
                map_redund_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_SPEED)
        begin
            if (legal255(wb_dat_i[7:0]))
                map_speed_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_MAP_BACKUP)
        begin
            if (legal255(wb_dat_i[7:0]))
                map_backup_r <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `A_SPEED_ID)
            speed_id_r <= wb_dat_i[7:0];
        else if (wb_adr_i == `A_DEACT)
            deact_r <= wb_dat_i[2:0];
        else if (wb_adr_i == `A_COMP_EN)
            comp_en_r <= wb_dat_i[1:0];
        else if (wb_adr_i == `A_MISMATCH_TOL)
            tol_r <= wb_dat_i[9:0];
        else if (wb_adr_i == `A_CH1_CURVE || wb_adr_i == `A_CH2_CURVE)
        begin
            if (wb_dat_i[7:0] == `CURVE_LINEAR || wb_dat_i[7:0] == `CURVE_FIVE)
                sh_curve_r[wb_adr_i[2]] <= wb_dat_i[7:0];
        end
        else if (cal_hit)
            sh_r[cal_i] <= wb_dat_i[9:0];
        else if (wb_adr_i == `A_COMMIT)
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                if (wb_dat_i[i] && cal_ok[i])
                begin
                    curve_r[i] <= sh_curve_r[i];
                    cal_r[i*5] <= sh_r[i*5];
                    cal_r[i*5+1] <= sh_r[i*5+1];
                    cal_r[i*5+2] <= sh_r[i*5+2];
                    cal_r[i*5+3] <= sh_r[i*5+3];
                    cal_r[i*5+4] <= sh_r[i*5+4];
                    refused_r[i] <= 1'b0;
                end
                else if (wb_dat_i[i])
                    refused_r[i] <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel acquisition, range check and scaling.
genvar c;
generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
        wire [9:0] raw = (c == 0) ? adc_ch1_i : adc_ch2_i;
        wire [9:0] vx = (vext_i < `VEXT_MIN) ? `VEXT_MIN :
            (vext_i > `VEXT_MAX) ? `VEXT_MAX : vext_i;
        wire [19:0] cmp_full = ({10'h000, raw} * {10'h000, `VEXT_NOM}) / {10'h000, vx};
        wire [9:0] cmp = (cmp_full > {10'h000, `CODE_MAX}) ? `CODE_MAX : cmp_full[9:0];
        wire [9:0] smp = comp_en_r[c] ? cmp : raw;
        reg [9:0] hist_r [0:4];
        reg [2:0] fill_r;
        reg [9:0] avg_r;
        reg bad_r;
        wire [12:0] sum = {3'b000, hist_r[0]} + {3'b000, hist_r[1]}
            + {3'b000, hist_r[2]} + {3'b000, hist_r[3]} + {3'b000, hist_r[4]};
        wire [26:0] prod = sum * `DIV5_MUL;
        // A channel is live only while something mapped and active owns it.
        wire [7:0] me = (c == 0) ? `MAP_CH1 : `MAP_CH2;
        assign ch_used[c] = ((map_high_r == me) & ~deact_r[0])
            | ((map_low_r == me) & ~deact_r[1]) | (map_pos_r == me)
            | (redund_on & pos_ana & (map_pos_r != me));
        integer j;
        always @(posedge clk_i)
        begin
            if (rst_i || !ch_used[c])
            begin
                fill_r <= 3'h0;
                avg_r <= 10'h000;
                bad_r <= 1'b0;
                for (j = 0; j < 5; j = j + 1)
                    hist_r[j] <= 10'h000;
            end
            else if (tick_r)
            begin
                for (j = 4; j > 0; j = j - 1)
                    hist_r[j] <= hist_r[j-1];
                hist_r[0] <= smp;
                if (fill_r != `AVG_TAPS)
                    fill_r <= fill_r + 3'h1;
                bad_r <= (smp < `FAULT_LO) | (smp > `FAULT_HI);
            end
            else if (fill_r == `AVG_TAPS)
                avg_r <= prod[25:16];
        end
        assign avg_w[c] = avg_r;
        assign range_bad[c] = bad_r;

        // Commit check on the shadow points: range limits and strict order.
        wire [9:0] s0 = sh_r[c*5];
        wire [9:0] s1 = sh_r[c*5+1];
        wire [9:0] s2 = sh_r[c*5+2];
        wire [9:0] s3 = sh_r[c*5+3];
        wire [9:0] s4 = sh_r[c*5+4];
        wire lin_s = (sh_curve_r[c] == `CURVE_LINEAR);
        wire in_rng = (s0 >= `CAL_LO) & (s0 <= `CAL_HI) & (s2 >= `CAL_LO)
            & (s2 <= `CAL_HI) & (s4 >= `CAL_LO) & (s4 <= `CAL_HI)
            & (lin_s | ((s1 >= `CAL_LO) & (s1 <= `CAL_HI)
            & (s3 >= `CAL_LO) & (s3 <= `CAL_HI)));
        wire up = lin_s ? ((s0 < s2) & (s2 < s4))
            : ((s0 < s1) & (s1 < s2) & (s2 < s3) & (s3 < s4));
        wire dn = lin_s ? ((s0 > s2) & (s2 > s4))
            : ((s0 > s1) & (s1 > s2) & (s2 > s3) & (s3 > s4));
        assign cal_ok[c] = in_rng & (up | dn);

        // Piecewise interpolation between neighbouring live points.
        wire signed [11:0] x = {2'b00, avg_r};
        wire signed [11:0] p0 = {2'b00, cal_r[c*5]};
        wire signed [11:0] p1 = {2'b00, cal_r[c*5+1]};
        wire signed [11:0] p2 = {2'b00, cal_r[c*5+2]};
        wire signed [11:0] p3 = {2'b00, cal_r[c*5+3]};
        wire signed [11:0] p4 = {2'b00, cal_r[c*5+4]};
        wire inc = (p4 > p0);
        wire lin = (curve_r[c] == `CURVE_LINEAR);
        reg signed [11:0] pa, pb, base, span;
        reg signed [11:0] out;
        reg signed [23:0] q;
        always @*
        begin
            pa = p0;
            pb = p2;
            base = -`DOM_FULL;
            span = `DOM_FULL;
            q = 24'sd0;
            if (lin)
            begin
                if (inc ? (x >= p2) : (x <= p2))
                begin
                    pa = p2;
                    pb = p4;
                    base = 12'sd0;
                end
            end
            else
            begin
                span = `DOM_HALF;
                if (inc ? (x >= p3) : (x <= p3))
                begin
                    pa = p3;
                    pb = p4;
                    base = `DOM_HALF;
                end
                else if (inc ? (x >= p2) : (x <= p2))
                begin
                    pa = p2;
                    pb = p3;
                    base = 12'sd0;
                end
                else if (inc ? (x >= p1) : (x <= p1))
                begin
                    pa = p1;
                    pb = p2;
                    base = -`DOM_HALF;
                end
                else
                begin
                    pb = p1;
                end
            end
            if (pb != pa)
                q = ((x - pa) * span) / (pb - pa);
            if (inc ? (x <= p0) : (x >= p0))
                out = -`DOM_FULL;
            else if (inc ? (x >= p4) : (x <= p4))
                out = `DOM_FULL;
            else
                out = base + q[11:0];
        end
        assign scl_w[c] = out;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Monitors, CAN gating and outputs. All outputs are registered.
wire signed [11:0] diff = scl_w[0] - scl_w[1];
wire [11:0] adiff = diff[11] ? (12'h000 - diff) : diff;
wire both_red = redund_on & pos_ana & (&ch_used);
reg can_ok;
always @*
begin
    can_ok = 1'b0;
    case (can_kind_i)
        `K_WHEEL: can_ok = (map_wheel_r == `MAP_PRESENT);
        `K_HIGH: can_ok = (map_high_r == `MAP_CAN) & ~deact_r[0];
        `K_LOW: can_ok = (map_low_r == `MAP_CAN) & ~deact_r[1];
        `K_POS: can_ok = (map_pos_r == `MAP_CAN);
        `K_SETPT: can_ok = (map_setpt_r == `MAP_PRESENT) & ~deact_r[2];
        `K_REDUND: can_ok = redund_on & (map_pos_r == `MAP_CAN);
        `K_SPEED: can_ok = (map_speed_r == `MAP_PRESENT) & (can_src_i == speed_id_r);
        default: can_ok = 1'b0;
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        can_accept_o <= 1'b0;
        backup_monitor_o <= 1'b0;
        signal_fault_o <= 1'b0;
        mismatch_o <= 1'b0;
        scaled_ch1_o <= 12'h000;
        scaled_ch2_o <= 12'h000;
    end
    else
    begin
        can_accept_o <= can_valid_i & can_ok;
        backup_monitor_o <= (map_backup_r == `MAP_PRESENT);
        signal_fault_o <= |range_bad;
        mismatch_o <= both_red & (adiff > {2'b00, tol_r});
        scaled_ch1_o <= scl_w[0];
        scaled_ch2_o <= scl_w[1];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone classic slave: ack one cycle after the request, one cycle long.
// Unmapped addresses read zero and ignore writes but still acknowledge.
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end
    else
    begin
        wb_ack_o <= rd_req;
        wb_dat_o <= 32'h00000000;
        if (!rd_req)
            wb_dat_o <= 32'h00000000;
        else if (wb_adr_i == `A_MAP_WHEEL)
            wb_dat_o[7:0] <= map_wheel_r;
        else if (wb_adr_i == `A_MAP_HIGH)
            wb_dat_o[7:0] <= map_high_r;
        else if (wb_adr_i == `A_MAP_LOW)
            wb_dat_o[7:0] <= map_low_r;
        else if (wb_adr_i == `A_MAP_POS)
            wb_dat_o[7:0] <= map_pos_r;
        else if (wb_adr_i == `A_MAP_SETPT)
            wb_dat_o[7:0] <= map_setpt_r;
        else if (wb_adr_i == `A_MAP_REDUND)
            wb_dat_o[7:0] <= map_redund_r;
        else if (wb_adr_i == `A_MAP_SPEED)
            wb_dat_o[7:0] <= map_speed_r;
        else if (wb_adr_i == `A_MAP_BACKUP)
            wb_dat_o[7:0] <= map_backup_r;
        else if (wb_adr_i == `A_SPEED_ID)
            wb_dat_o[7:0] <= speed_id_r;
        else if (wb_adr_i == `A_DEACT)
            wb_dat_o[2:0] <= deact_r;
        else if (wb_adr_i == `A_COMP_EN)
            wb_dat_o[1:0] <= comp_en_r;
        else if (wb_adr_i == `A_MISMATCH_TOL)
            wb_dat_o[9:0] <= tol_r;
        else if (wb_adr_i == `A_CH1_CURVE || wb_adr_i == `A_CH2_CURVE)
            wb_dat_o[7:0] <= curve_r[wb_adr_i[2]];
        else if (cal_hit)
            wb_dat_o[9:0] <= cal_r[cal_i];
        else if (wb_adr_i == `A_STATUS)
            wb_dat_o[5:0] <= {mismatch_o, signal_fault_o, refused_r, range_bad};
        else if (wb_adr_i == `A_CH1_AVG)
            wb_dat_o[9:0] <= avg_w[0];
        else if (wb_adr_i == `A_CH2_AVG)
            wb_dat_o[9:0] <= avg_w[1];
        else if (wb_adr_i == `A_CH1_SCALED)
            wb_dat_o <= {{20{scl_w[0][11]}}, scl_w[0]};
        else if (wb_adr_i == `A_CH2_SCALED)
            wb_dat_o <= {{20{scl_w[1][11]}}, scl_w[1]};
    end
end

endmodule // steering_input_map_scaling

// ---- core/steering_input_regs.vh ----
`ifndef STEERING_INPUT_REGS_VH
`define STEERING_INPUT_REGS_VH
// Register byte offsets, one 32-bit word each.
`define A_MAP_WHEEL 8'h00
`define A_MAP_HIGH 8'h04
`define A_MAP_LOW 8'h08
`define A_MAP_POS 8'h0c
`define A_MAP_SETPT 8'h10
`define A_MAP_REDUND 8'h14
`define A_MAP_SPEED 8'h18
`define A_MAP_BACKUP 8'h1c
`define A_SPEED_ID 8'h20
`define A_DEACT 8'h24
`define A_COMP_EN 8'h28
`define A_CH1_CURVE 8'h30
`define A_CH2_CURVE 8'h34
`define A_CAL_BASE 8'h40
`define A_COMMIT 8'h80
`define A_STATUS 8'h84
`define A_CH1_AVG 8'h88
`define A_CH2_AVG 8'h8c
`define A_CH1_SCALED 8'h90
`define A_CH2_SCALED 8'h94
`define A_MISMATCH_TOL 8'h98
// Mapping codes.
`define MAP_NONE 8'h00
`define MAP_CH1 8'h01
`define MAP_CH2 8'h02
`define MAP_CAN 8'h04
`define MAP_PRESENT 8'hff
`define CURVE_LINEAR 8'hff
`define CURVE_FIVE 8'h00
// CAN message kinds presented on can_kind_i.
`define K_WHEEL 3'h0
`define K_HIGH 3'h1
`define K_LOW 3'h2
`define K_POS 3'h3
`define K_SETPT 3'h4
`define K_REDUND 3'h5
`define K_SPEED 3'h6
// Sample codes.
`define CODE_MAX 10'h3ff
`define FAULT_LO 10'd20
`define FAULT_HI 10'd967
`define CAL_LO 10'd30
`define CAL_HI 10'd957
`define CAL_RST_L 10'd100
`define CAL_RST_HL 10'd300
`define CAL_RST_N 10'd500
`define CAL_RST_HR 10'd700
`define CAL_RST_R 10'd900
`define TOL_RST 10'd20
// Supply in hundredths of a volt.
`define VEXT_NOM 10'd500
`define VEXT_MIN 10'd480
`define VEXT_MAX 10'd520
// Calculation domain ends.
`define DOM_FULL 12'sd1000
`define DOM_HALF 12'sd500
// Timing.
`define AVG_TAPS 3'd5
`define WINDOW_MS 5
`define CLK_KHZ 100000
`define DIV5_MUL 14'd13108
`endif

// ---- verif/steer_map_chk_sva.sv ----
`timescale 1ns/10ps
module steer_map_chk #(
    parameter [16:0] SAMPLE_CYCLES = 17'd20
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire can_valid_i,
    input wire can_accept_o,
    input wire backup_monitor_o,
    input wire signal_fault_o,
    input wire mismatch_o,
    input wire [11:0] scaled_ch1_o,
    input wire [11:0] scaled_ch2_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Ack one cycle after a request, one cycle long.
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_caused: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("bus answer without a request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("stale read data");
    // Accepts follow a presented message.
    a_accept_cause: assert property (can_accept_o |-> $past(can_valid_i))
        else $error("accept without message");
    // Nothing is mapped after reset.
    a_reset_clear: assert property ($fell(rst_i) |->
        !(can_accept_o || backup_monitor_o || signal_fault_o || mismatch_o))
        else $error("flag set after reset");
    // Backup flag only moves after a bus access.
    a_backup_by_bus: assert property ($changed(backup_monitor_o) |->
        wb_ack_o || $past(wb_ack_o))
        else $error("backup moved without access");
    // Scaled values stay in the domain.
    a_scaled_span: assert property ($signed(scaled_ch1_o) >= -12'sd1000 &&
        $signed(scaled_ch1_o) <= 12'sd1000 && $signed(scaled_ch2_o) >= -12'sd1000
        && $signed(scaled_ch2_o) <= 12'sd1000)
        else $error("scaled out of domain");
    c_accept: cover property (can_accept_o);
    c_fault: cover property ($rose(signal_fault_o));
    c_mismatch: cover property ($rose(mismatch_o));
endmodule // steer_map_chk

bind steering_input_map_scaling steer_map_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .can_valid_i(can_valid_i),
    .can_accept_o(can_accept_o),
    .backup_monitor_o(backup_monitor_o),
    .signal_fault_o(signal_fault_o),
    .mismatch_o(mismatch_o),
    .scaled_ch1_o(scaled_ch1_o),
    .scaled_ch2_o(scaled_ch2_o)
);

// ---- verif/steer_sensor_model.sv ----
`timescale 1ns/10ps
// Analogue sensors and CAN nodes.
module steer_sensor_model (
    input wire clk_i,
    output reg [9:0] ch1_o,
    output reg [9:0] ch2_o,
    output reg [9:0] vext_o,
    output reg valid_o,
    output reg [2:0] kind_o,
    output reg [7:0] src_o
);
    // Nominal supply, bus idle.
    initial
    begin
        ch1_o = 10'h000;
        ch2_o = 10'h000;
        vext_o = 10'h1f4;
        valid_o = 1'b0;
        kind_o = 3'h0;
        src_o = 8'h00;
    end
    // Steady levels let averages settle.
    task set_adc(input [9:0] a, input [9:0] b);
    begin
        @(posedge clk_i);
        ch1_o <= a;
        ch2_o <= b;
    end
    endtask
    // One message for one cycle, then inverse lines.
    task send(input [2:0] k, input [7:0] s);
    begin
        @(posedge clk_i);
        valid_o <= 1'b1;
        kind_o <= k;
        src_o <= s;
        @(posedge clk_i);
        valid_o <= 1'b0;
        kind_o <= ~k;
        src_o <= ~s;
    end
    endtask
endmodule // steer_sensor_model

// ---- verif/steering_input_map_scaling_tb_top.sv ----
`timescale 1ns/10ps
`include "steering_input_regs.vh"
module steering_input_map_scaling_tb_top;
    localparam [16:0] SC = 17'd20;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h0;
    reg [31:0] base;
    reg [31:0] rq[$];
    reg [31:0] cq[$];
    reg cv_d = 1'b0;
    wire [31:0] rdat;
    wire ack, acc, bkp, flt, mis, cv;
    wire [11:0] sc1, sc2;
    wire [9:0] a1, a2, vx;
    wire [2:0] ck;
    wire [7:0] cs;
    integer err_count = 0;
    integer num_checks = 0;
    integer i, j;
    ////////////////////////////////////////////////////////////////////////////////
    steering_input_map_scaling #(.SAMPLE_CYCLES(SC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_ch1_i(a1), .adc_ch2_i(a2),
        .vext_i(vx), .can_valid_i(cv), .can_kind_i(ck), .can_src_i(cs), .can_accept_o(acc),
        .backup_monitor_o(bkp), .signal_fault_o(flt), .mismatch_o(mis),
        .scaled_ch1_o(sc1), .scaled_ch2_o(sc2));
    steer_sensor_model SENS (.clk_i(clk_i), .ch1_o(a1), .ch2_o(a2), .vext_o(vx),
        .valid_o(cv), .kind_o(ck), .src_o(cs));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task stop_test;
    begin
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // Held until ack is seen, then released.
    task wb(input [7:0] a, input w, input [31:0] d);
    begin
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [31:0] e);
    begin
        rq.push_back(e);
        wb(a, 1'b0, 32'h0);
    end
    endtask
    task can_try(input [2:0] k, input [7:0] s, input e);
    begin
        cq.push_back({31'h0, e});
        SENS.send(k, s);
    end
    endtask
    // Five ticks refill an average; one tick updates the range flag.
    task wait_ticks(input integer n);
    begin
        repeat (n * SC + 4) @(posedge clk_i);
    end
    endtask
    // Queued notes are checked as results appear.
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0)
            chk(rdat, rq.pop_front());
        if (cv_d)
            chk({31'h0, acc}, cq.pop_front());
        cv_d <= cv;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count = err_count + 1;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        base = $urandom(32'h7d268cb7);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            rd(8'(i * 4), 32'h0);
        rd(`A_CH1_CURVE, 32'hff);
        rd(`A_CAL_BASE, 32'h64);
        rd(8'h48, 32'h1f4);
        rd(8'h50, 32'h384);
        rd(8'h44, 32'h12c);
        rd(8'h4c, 32'h2bc);
        wb(8'hfc, 1'b1, 32'h5a);
        rd(8'hfc, 32'h0);
        // Unmapped: shorted pin and messages ignored.
        SENS.set_adc(10'h005, base[9:0]);
        wait_ticks(1);
        chk({31'h0, flt}, 32'h0);
        for (i = 0; i < 7; i = i + 1)
            can_try(3'(i), 8'h11, 1'b0);
        // Legal codes stick, anything else is dropped.
        for (i = 1; i < 4; i = i + 1)
        begin
            for (j = 0; j < 4; j = j + 1)
            begin
                wb(8'(i * 4), 1'b1, 32'(j == 3 ? 3 : 1 << j));
                rd(8'(i * 4), 32'(j == 3 ? 4 : 1 << j));
            end
            wb(8'(i * 4), 1'b1, 32'h0);
        end
        wb(`A_MAP_WHEEL, 1'b1, 32'hff);
        wb(`A_MAP_WHEEL, 1'b1, 32'h1);
        rd(`A_MAP_WHEEL, 32'hff);
        can_try(`K_WHEEL, 8'h21, 1'b1);
        wb(`A_MAP_HIGH, 1'b1, 32'h4);
        can_try(`K_HIGH, 8'h22, 1'b1);
        wb(`A_DEACT, 1'b1, 32'h1);
        can_try(`K_HIGH, 8'h22, 1'b0);
        wb(`A_MAP_SETPT, 1'b1, 32'hff);
        can_try(`K_SETPT, 8'h23, 1'b1);
        wb(`A_DEACT, 1'b1, 32'h5);
        can_try(`K_SETPT, 8'h23, 1'b0);
        wb(`A_SPEED_ID, 1'b1, {24'h0, base[7:0]});
        wb(`A_MAP_SPEED, 1'b1, 32'hff);
        can_try(`K_SPEED, base[7:0], 1'b1);
        can_try(`K_SPEED, base[7:0] ^ (base[15:8] | 8'h01), 1'b0);
        wb(`A_MAP_BACKUP, 1'b1, 32'hff);
        repeat (2) @(posedge clk_i);
        chk({31'h0, bkp}, 32'h1);
        // Position on channel one; both range bounds.
        wb(`A_MAP_POS, 1'b1, 32'h1);
        for (j = 0; j < 4; j = j + 1)
        begin
            SENS.set_adc(10'(j < 2 ? 19 + j : 965 + j), 10'h2bc);
            wait_ticks(1);
            chk({31'h0, flt}, 32'(j == 0 || j == 3));
        end
        rd(`A_STATUS, 32'h11);
        SENS.set_adc(10'h2bc, base[25:16]);
        wait_ticks(6);
        rd(`A_CH1_AVG, 32'h2bc);
        chk({20'h0, sc1}, 32'h1f4);
        // Redundant sensor on channel two, compared.
        wb(`A_MAP_REDUND, 1'b1, 32'hff);
        SENS.set_adc(10'h2bc, 10'h2bc - {7'h0, base[18:16]});
        wait_ticks(6);
        chk({31'h0, mis}, 32'h0);
        SENS.set_adc(10'h2bc, 10'h12c);
        wait_ticks(6);
        chk({20'h0, sc2}, 32'he0c);
        chk({31'h0, mis}, 32'h1);
        // Non-monotonic set refused; live points remain.
        wb(`A_CAL_BASE, 1'b1, 32'h1f4);
        wb(8'h48, 1'b1, 32'h12c);
        wb(`A_COMMIT, 1'b1, 32'h1);
        rd(`A_CAL_BASE, 32'h64);
        rd(`A_STATUS, 32'h24);
        // Five-point curve with a moved half-right point.
        wb(`A_CAL_BASE, 1'b1, 32'h64);
        wb(8'h48, 1'b1, 32'h1f4);
        wb(8'h4c, 1'b1, 32'h320);
        wb(`A_CH1_CURVE, 1'b1, 32'h0);
        wb(`A_COMMIT, 1'b1, 32'h1);
        rd(`A_CH1_CURVE, 32'h0);
        rd(`A_STATUS, 32'h20);
        SENS.set_adc(10'h320, 10'h12c);
        wait_ticks(6);
        chk({20'h0, sc1}, 32'h1f4);
        wb(`A_COMP_EN, 1'b1, 32'h1);
        SENS.vext_o <= 10'h208;
        SENS.set_adc(10'h3e8, 10'h12c);
        wait_ticks(1);
        chk({31'h0, flt}, 32'h0);
        stop_test;
    end
endmodule // steering_input_map_scaling_tb_top
